// ==== ethernet_irq_enable_mask.sv ====
// Interrupt enable mask and active-low interrupt pin gating
//
// Summary of operation
// - Enable bit 0 lets the receive error flag reach the pin, else masks it.
// - Enable bit 1 lets the transmit error flag reach the pin, else masks it.
// - Enable bit 3 lets the transmit done flag reach the pin, else masks it.
// - Enable bit 4 lets the link change flag reach the pin, else masks it.
// - Enable bit 6 lets the receive pending flag reach the pin, else masks it.
// - A read-only pending bit is set while any of flags 0, 1 and 3 to 6 is set and enabled.
// - With global enable set and an interrupt pending the pin goes low.
// - Clearing the global enable returns the pin high.
// - Setting global enable with a pending interrupt gives a new falling edge.
//
// Decided for this implementation: strobed register access and the register addresses.
`include "irq_enable_params.svh"
`timescale 1ns/1ns
`default_nettype none

module ethernet_irq_enable_mask (
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic       clk_en,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic [7:0] irq_flags,
	output logic            irq_pin_n,
	output logic            irq_pending,
	output logic            event_irq
);

	// ==========================================================
	// Helpers
	// ==========================================================
	function automatic logic [7:0] gate_sources(
		input logic [7:0] flags,
		input logic [7:0] enables
	);
		gate_sources = flags & enables & `SOURCE_MASK;
	endfunction : gate_sources

	irq_enable_pkg::reg_req_s   req;
	logic [7:0]                 interrupt_enable_mask;
	logic [1:0]                 event_status;
	logic [1:0]                 event_mask;
	logic [7:0]                 gated;
	logic                       any_pending;
	logic                       global_irq_pin_enable;
	logic                       next_pin_n;
	logic [1:0]                 event_set;
	logic                       prev_pin_n;
	irq_enable_pkg::pin_state_e pin_state;
	irq_enable_pkg::pin_state_e next_pin_state;

	assign req.addr  = reg_addr;
	assign req.wdata = reg_wdata;
	assign req.wr    = reg_wr;
	assign req.rd    = reg_rd;

	// ==========================================================
	// Source gating
	// ==========================================================
	always_comb begin
		gated = gate_sources(irq_flags, interrupt_enable_mask);
		any_pending = |gated;
		global_irq_pin_enable = interrupt_enable_mask[`BIT_GLOBAL_ENABLE];
	end

	// ==========================================================
	// Pin state machine
	// ==========================================================
	always_comb begin
		next_pin_state = pin_state;
		case (pin_state)
			irq_enable_pkg::PIN_IDLE: begin
				if (any_pending && global_irq_pin_enable) begin
					next_pin_state = irq_enable_pkg::PIN_ASSERT;
				end else if (any_pending) begin
					next_pin_state = irq_enable_pkg::PIN_BLOCKED;
				end
			end
			irq_enable_pkg::PIN_ASSERT: begin
				if (!any_pending) begin
					next_pin_state = irq_enable_pkg::PIN_IDLE;
				end else if (!global_irq_pin_enable) begin
					next_pin_state = irq_enable_pkg::PIN_BLOCKED;
				end
			end
			irq_enable_pkg::PIN_BLOCKED: begin
				if (!any_pending) begin
					next_pin_state = irq_enable_pkg::PIN_IDLE;
				end else if (global_irq_pin_enable) begin
					next_pin_state = irq_enable_pkg::PIN_ASSERT;
				end
			end
			default: begin
				next_pin_state = irq_enable_pkg::PIN_IDLE;
			end
		endcase
		next_pin_n = (next_pin_state != irq_enable_pkg::PIN_ASSERT);
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_state <= irq_enable_pkg::PIN_IDLE;
		end else if (clk_en) begin
			pin_state <= next_pin_state;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq_pin_n  <= 1'b1;
			prev_pin_n <= 1'b1;
		end else if (clk_en) begin
			irq_pin_n  <= next_pin_n;
			prev_pin_n <= irq_pin_n;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq_pending <= 1'b0;
		end else if (clk_en) begin
			irq_pending <= any_pending;
		end
	end

	// ==========================================================
	// Enable register
	// ==========================================================
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			interrupt_enable_mask <= `RESET_ENABLE_MASK;
		end else if (clk_en && req.wr && req.addr == `ADDR_ENABLE_MASK) begin
			interrupt_enable_mask <= req.wdata;
		end
	end

	// ==========================================================
	// Event status and mask
	// ==========================================================
	// Event 0: pin fell, event 1: pin rose
	always_comb begin
		event_set = {~prev_pin_n & irq_pin_n, prev_pin_n & ~irq_pin_n};
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			event_status <= 2'h0;
		end else if (clk_en) begin
			// Set wins over a write-one clear
			if (req.wr && req.addr == `ADDR_EVENT_STATUS) begin
				event_status <= (event_status & ~req.wdata[1:0]) | event_set;
			end else begin
				event_status <= event_status | event_set;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			event_mask <= `RESET_EVENT_MASK;
		end else if (clk_en && req.wr && req.addr == `ADDR_EVENT_MASK) begin
			event_mask <= req.wdata[1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			event_irq <= 1'b0;
		end else if (clk_en) begin
			event_irq <= |(event_status & event_mask);
		end
	end

	// ==========================================================
	// Read port
	// ==========================================================
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (clk_en) begin
			reg_rdata <= 8'h00;
			if (req.rd) begin
				case (req.addr)
					`ADDR_ENABLE_MASK:  reg_rdata <= interrupt_enable_mask;
					`ADDR_PIN_STATUS:   reg_rdata <= {6'h00, ~irq_pin_n, irq_pending};
					`ADDR_EVENT_STATUS: reg_rdata <= {6'h00, event_status};
					`ADDR_EVENT_MASK:   reg_rdata <= {6'h00, event_mask};
					default:            reg_rdata <= 8'h00;
				endcase
			end
		end
	end

endmodule : ethernet_irq_enable_mask
`default_nettype wire

// ==== irq_enable_checker.sv ====
// Assertion checker for the interrupt enable block
`timescale 1ns/1ns
`default_nettype none
module irq_enable_checker (
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic       clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] irq_flags,
	input wire logic       irq_pin_n,
	input wire logic       irq_pending
);
	logic [7:0] m;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) m <= 8'h00;
		else if (clk_en && reg_wr && reg_addr == 4'h0) m <= reg_wdata;
	end
	default clocking dcb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// ========================================
	// Assertions
	a_pend_value: assert property (
		irq_pending == |($past(irq_flags) & $past(m) & 8'h7b)) else $error("pend");
	a_pin_value: assert property (
		irq_pin_n == !(irq_pending && $past(m[7]))) else $error("pin");
	a_pin_needs_pend: assert property (
		!irq_pin_n |-> irq_pending) else $error("pin no pend");
	a_pin_refall: assert property (
		$rose(m[7]) && irq_pending && $stable(irq_flags) |=> $fell(irq_pin_n))
		else $error("no fall");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("rdata idle");
	a_rdata_mask: assert property (
		$past(reg_rd) && $past(reg_addr) == 4'h0 |-> reg_rdata == $past(m))
		else $error("mask read");
	a_rdata_status: assert property ($past(reg_rd) && $past(reg_addr) == 4'h1
		|-> reg_rdata == {6'h00, !$past(irq_pin_n), $past(irq_pending)})
		else $error("status read");
	a_rdata_unmapped: assert property ($past(reg_rd) && $past(reg_addr) > 4'h3
		|-> reg_rdata == 8'h00) else $error("unmapped read");
	c_pin_low: cover property (!irq_pin_n);
	c_refall: cover property ($rose(m[7]) && irq_pending);
	c_read: cover property (reg_rd);
endmodule : irq_enable_checker
bind ethernet_irq_enable_mask irq_enable_checker chk (.clk_sys(clk_sys),
	.rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_flags(irq_flags),
	.irq_pin_n(irq_pin_n), .irq_pending(irq_pending));
`default_nettype wire

// ==== irq_enable_params.svh ====
// Offsets, bit positions and reset values of the interrupt enable block
`ifndef IRQ_ENABLE_PARAMS_SVH
`define IRQ_ENABLE_PARAMS_SVH
`define ADDR_ENABLE_MASK   4'h0
`define ADDR_PIN_STATUS    4'h1
`define ADDR_EVENT_STATUS  4'h2
`define ADDR_EVENT_MASK    4'h3
`define BIT_RX_ERROR       0
`define BIT_TX_ERROR       1
`define BIT_RESERVED       2
`define BIT_TX_DONE        3
`define BIT_LINK_CHANGE    4
`define BIT_COPY_ENGINE    5
`define BIT_RX_PENDING     6
`define BIT_GLOBAL_ENABLE  7
`define BIT_PENDING        0
`define BIT_PIN_LEVEL      1
`define SOURCE_MASK        8'h7b
`define RESET_ENABLE_MASK  8'h00
`define RESET_EVENT_MASK   2'h0
`define EVENT_BITS         2
`endif

// ==== irq_enable_pkg.sv ====
// Types shared by the interrupt enable block
package irq_enable_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_s;
	typedef enum logic [1:0] {
		PIN_IDLE    = 2'b00,
		PIN_ASSERT  = 2'b01,
		PIN_BLOCKED = 2'b10
	} pin_state_e;
endpackage : irq_enable_pkg

// ==== irq_host.sv ====
// Host model counting falling edges of the interrupt pin
`timescale 1ns/1ns
`default_nettype none
module irq_host (
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic       irq_pin_n,
	output var  logic [7:0] falls
);
	logic last;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			last  <= 1'b1;
			falls <= 8'h00;
		end else begin
			last <= irq_pin_n;
			if (last && !irq_pin_n) falls <= falls + 8'h01;
		end
	end
endmodule : irq_host
`default_nettype wire

// ==== tb.sv ====
// Testbench for the interrupt enable block
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic       clk_sys = 1'b0;
	logic       rstn = 1'b0;
	logic       clk_en = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] irq_flags = 8'h00;
	logic [7:0] reg_rdata;
	logic       irq_pin_n;
	logic       irq_pending;
	logic       event_irq;
	logic [7:0] falls;
	int         mismatches = 0;
	int         n_tests = 0;
	int         cycles = 0;
	always #5 clk_sys = ~clk_sys;
	ethernet_irq_enable_mask dut (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_flags(irq_flags),
		.irq_pin_n(irq_pin_n), .irq_pending(irq_pending), .event_irq(event_irq));
	irq_host host (.clk_sys(clk_sys), .rstn(rstn), .irq_pin_n(irq_pin_n),
		.falls(falls));
	task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 check("rdata", reg_rdata, e);
	endtask : rd
	task automatic pin(input logic [7:0] e);
		repeat (2) @(posedge clk_sys);
		#1 check("pend_pin", {6'h00, irq_pending, irq_pin_n}, e);
	endtask : pin
	task automatic give_verdict;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(4'h0, 8'h00);
		pin(8'h01);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys) irq_flags <= 8'h01 << i;
			wr(4'h0, 8'h80 | (8'h01 << i));
			pin((i == 2 || i == 7) ? 8'h01 : 8'h02);
			wr(4'h0, 8'h80);
			pin(8'h01);
		end
		$display("test sources done");
		@(posedge clk_sys) irq_flags <= 8'h01;
		wr(4'h3, 8'h00);
		wr(4'h2, 8'h03);
		wr(4'h0, 8'h81);
		pin(8'h02);
		rd(4'h1, 8'h03);
		check("masked", {7'h00, event_irq}, 8'h00);
		wr(4'h3, 8'h03);
		rd(4'h2, 8'h01);
		check("event", {7'h00, event_irq}, 8'h01);
		wr(4'h0, 8'h01);
		pin(8'h03);
		rd(4'h2, 8'h03);
		wr(4'h2, 8'h03);
		rd(4'h2, 8'h00);
		check("cleared", {7'h00, event_irq}, 8'h00);
		wr(4'h0, 8'h81);
		pin(8'h02);
		check("falls", falls, 8'h08);
		$display("test events done");
		@(posedge clk_sys) clk_en <= 1'b0;
		wr(4'h0, 8'h00);
		@(posedge clk_sys) clk_en <= 1'b1;
		pin(8'h02);
		rd(4'h0, 8'h81);
		check("frozen falls", falls, 8'h08);
		$display("test freeze done");
		wr(4'hf, 8'hff);
		rd(4'hf, 8'h00);
		rd(4'h0, 8'h81);
		$display("test unmapped done");
		give_verdict();
	end
endmodule : tb
`default_nettype wire
